// ==== hdl/ebp_consts.svh ====
// Register offsets, field positions and reset values of the expansion bus port.
`ifndef EBP_CONSTS_SVH
`define EBP_CONSTS_SVH
`define EBP_OFS_CONFIG 8'h7C
`define EBP_OFS_COMMAND 8'h80
`define EBP_OFS_PAGING 8'h84
`define EBP_OFS_ADDR_DATA 8'h88
`define EBP_CFG_HALT_EN 31
`define EBP_CFG_RESUME 30
`define EBP_CFG_FAST 28
`define EBP_CFG_TMR_HI 25
`define EBP_CFG_TMR_LO 22
`define EBP_CFG_SWAP_HI 21
`define EBP_CFG_SWAP_LO 20
`define EBP_CFG_WIDE 19
`define EBP_CFG_INCR 18
`define EBP_CFG_STROBE_STYLE 17
`define EBP_CFG_TMR_EN_N 16
`define EBP_CFG_MASK 32'hD3FF0000
`define EBP_PAGE_MASK 32'hFFFFF800
`define EBP_PAGE_EN 11
`define EBP_CMD_LEN_HI 31
`define EBP_CMD_LEN_LO 17
`define EBP_CMD_DIR 16
`define EBP_IMM_MAX 15'h0004
`define EBP_CFG_RESET 32'h00010000
`define EBP_REG_RESET 32'h00000000
`define EBP_SWAP_NONE 2'h0
`define EBP_SWAP_2B 2'h1
`define EBP_SWAP_4B 2'h2
`define EBP_GAP_FAST 2'h1
`define EBP_GAP_SLOW 2'h2
`define EBP_ADDR_CYC 2'h2
`define EBP_FIFO_DEPTH 8
`define EBP_FIFO_WIDTH 32
`endif

// ==== hdl/ebp_pkg.sv ====
// Types shared by the expansion bus port logic.
package ebp_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } ebp_reg_req_t;
  typedef struct packed {
    logic ale;
    logic rd_n;
    logic wr_n;
    logic ad_oe;
    logic [15:0] ad_out;
  } ebp_pins_t;
  typedef enum logic [4:0] {
    EBP_IDLE = 5'h01,
    EBP_ADDR = 5'h02,
    EBP_STRB = 5'h04,
    EBP_GAP = 5'h08,
    EBP_HOLD = 5'h10
  } ebp_state_t;
endpackage

// ==== hdl/ebp_top.sv ====
// Expansion bus port: register set, transfer engine and its data FIFO.
`timescale 1ns/100ps
`include "ebp_consts.svh"

module ebp_fifo #(parameter int WIDTH = 32, parameter int DEPTH = 8) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Filling side.
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side.
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;
  // Flags come from the count so full and empty are exact.
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wp_nxt = push ? AW'(wp_r + 1'b1) : wp_r;
    rp_nxt = pop ? AW'(rp_r + 1'b1) : rp_r;
    cnt_nxt = (AW+1)'(cnt_r + push - pop);
  end
  assign in_ready = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem[rp_r];
  // Storage has no reset; only the pointers and the count need a defined value.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule // ebp_fifo

module ebp_top (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Register access and the upload strobe that follows it.
  input wire ebp_pkg::ebp_reg_req_t reg_req,
  input wire logic reg_upload,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // DMA side of the data path.
  input wire logic dma_in_valid,
  input wire logic [31:0] dma_in_data,
  output logic dma_in_ready,
  output logic dma_out_valid,
  output logic [31:0] dma_out_data,
  input wire logic dma_out_ready,
  output logic [31:0] dma_addr,
  output logic [19:0] dma_page_base,
  output logic dma_page_en,
  // Target bus pins.
  output ebp_pkg::ebp_pins_t pins,
  input wire logic [15:0] tgt_ad_in,
  input wire logic tgt_rdy,
  input wire logic ext_halt_input,
  // Status.
  output logic active
);
  import ebp_pkg::*;
  logic [31:0] cfg_r, cfg_nxt, cmd_r, cmd_nxt, page_r, page_nxt, ad_r, ad_nxt;
  logic [31:0] rdata_r, rdata_nxt, asm_r, asm_nxt;
  logic rvalid_r, rvalid_nxt, pend_r, pend_nxt, blk_r, blk_nxt, stop_r, stop_nxt;
  logic act_r, act_nxt;
  ebp_state_t st_r, st_nxt;
  logic [3:0] tmr_r, tmr_nxt;
  logic [1:0] idx_r, idx_nxt, gap_r, gap_nxt;
  ebp_pins_t pins_r, pins_nxt;
  logic [19:0] pbase_r, pbase_nxt;
  logic [15:0] ad_s1_r, ad_s2_r;
  logic rdy_s1_r, rdy_s2_r, halt_s1_r, halt_s2_r;
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [31:0] f_in_data, f_out_data, src_word, shifted;
  logic [14:0] len, nbytes;
  logic dir_rd, wide2, strobe_done, halt_req, can_go, last;

  // Endian swap applied to every Dword crossing the FIFO.
  function automatic logic [31:0] swap_dw(input logic [31:0] w, input logic [1:0] m);
    if (m == `EBP_SWAP_2B) begin
      swap_dw = {w[23:16], w[31:24], w[7:0], w[15:8]};
    end else if (m == `EBP_SWAP_4B) begin
      swap_dw = {w[7:0], w[15:8], w[23:16], w[31:24]};
    end else begin
      swap_dw = w;
    end
  endfunction

  // Pins are foreign to this clock, so each passes two flip-flops first.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ad_s1_r <= 16'h0000;
      ad_s2_r <= 16'h0000;
      rdy_s1_r <= 1'b1;
      rdy_s2_r <= 1'b1;
      halt_s1_r <= 1'b1;
      halt_s2_r <= 1'b1;
    end else begin
      ad_s1_r <= tgt_ad_in;
      ad_s2_r <= ad_s1_r;
      rdy_s1_r <= tgt_rdy;
      rdy_s2_r <= rdy_s1_r;
      halt_s1_r <= ext_halt_input;
      halt_s2_r <= halt_s1_r;
    end
  end

  // FIFO ports are steered by the transfer direction.
  ebp_fifo #(.WIDTH(`EBP_FIFO_WIDTH), .DEPTH(`EBP_FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_valid(f_in_valid),
    .in_data(f_in_data),
    .in_ready(f_in_ready),
    .out_valid(f_out_valid),
    .out_data(f_out_data),
    .out_ready(f_out_ready)
  );

  // Derived transfer terms.
  always_comb begin
    len = cmd_r[`EBP_CMD_LEN_HI:`EBP_CMD_LEN_LO];
    dir_rd = cmd_r[`EBP_CMD_DIR];
    wide2 = cfg_r[`EBP_CFG_WIDE] && !idx_r[0] && (len > 15'h0001);
    nbytes = wide2 ? 15'h0002 : 15'h0001;
    last = (len == nbytes) || (idx_r == (wide2 ? 2'h2 : 2'h3));
    src_word = blk_r ? swap_dw(f_out_data, cfg_r[`EBP_CFG_SWAP_HI:`EBP_CFG_SWAP_LO]) : ad_r;
    shifted = src_word >> {idx_r, 3'h0};
    // Timer setting plus one cycle when enabled, then wait for ready.
    strobe_done = (cfg_r[`EBP_CFG_TMR_EN_N] || (tmr_r >= cfg_r[`EBP_CFG_TMR_HI:`EBP_CFG_TMR_LO]))
      && rdy_s2_r;
    halt_req = blk_r && cfg_r[`EBP_CFG_HALT_EN] && !halt_s2_r;
    can_go = !blk_r || (dir_rd ? f_in_ready : f_out_valid);
  end

  // DMA side: pushes in write direction, pops in read direction.
  always_comb begin
    dma_in_ready = act_r && blk_r && !dir_rd && f_in_ready;
    dma_out_valid = f_out_valid && dir_rd;
    dma_out_data = f_out_data;
    f_in_valid = dir_rd ? 1'b0 : (dma_in_valid && act_r && blk_r);
    f_in_data = dma_in_data;
    f_out_ready = dir_rd ? dma_out_ready : 1'b0;
    if (dir_rd && st_r == EBP_STRB && strobe_done && blk_r && last) begin
      f_in_valid = 1'b1;
    end
    if (dir_rd) begin
      f_in_data = swap_dw(asm_nxt, cfg_r[`EBP_CFG_SWAP_HI:`EBP_CFG_SWAP_LO]);
    end
    if (!dir_rd && st_r == EBP_STRB && strobe_done && blk_r && last) begin
      f_out_ready = 1'b1;
    end
  end

  // Register file and transfer sequencer.
  always_comb begin
    cfg_nxt = cfg_r;
    cmd_nxt = cmd_r;
    page_nxt = page_r;
    ad_nxt = ad_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = reg_req.rd;
    pend_nxt = pend_r;
    blk_nxt = blk_r;
    stop_nxt = stop_r;
    act_nxt = act_r;
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    idx_nxt = idx_r;
    gap_nxt = gap_r;
    asm_nxt = asm_r;
    pins_nxt = pins_r;
    pins_nxt.ale = 1'b0;
    pbase_nxt = page_r[`EBP_PAGE_EN] ? page_r[31:12] : 20'h00000;
    // Reads answer one cycle later; reserved bits are masked to zero.
    if (reg_req.rd) begin
      if (reg_req.addr == `EBP_OFS_CONFIG) begin
        rdata_nxt = cfg_r;
      end else if (reg_req.addr == `EBP_OFS_COMMAND) begin
        rdata_nxt = cmd_r;
      end else if (reg_req.addr == `EBP_OFS_PAGING) begin
        rdata_nxt = page_r;
      end else if (reg_req.addr == `EBP_OFS_ADDR_DATA) begin
        rdata_nxt = ad_r;
      end else begin
        rdata_nxt = 32'h00000000;
      end
    end
    // Writes are ignored while a transfer owns the registers.
    if (reg_req.wr && !act_r) begin
      if (reg_req.addr == `EBP_OFS_CONFIG) begin
        cfg_nxt = reg_req.wdata & `EBP_CFG_MASK;
      end else if (reg_req.addr == `EBP_OFS_COMMAND) begin
        cmd_nxt = reg_req.wdata;
        pend_nxt = 1'b1;
      end else if (reg_req.addr == `EBP_OFS_PAGING) begin
        page_nxt = reg_req.wdata & `EBP_PAGE_MASK;
      end else if (reg_req.addr == `EBP_OFS_ADDR_DATA) begin
        ad_nxt = reg_req.wdata;
      end
    end
    // Each Dword moved on the DMA side advances the PCI address.
    if (blk_r && ((dma_in_valid && dma_in_ready) || (dma_out_valid && dma_out_ready))) begin
      ad_nxt = ad_r + 32'h00000004;
    end
    case (st_r)
      EBP_IDLE: begin
        pins_nxt.ad_oe = 1'b0;
        pins_nxt.rd_n = 1'b1;
        pins_nxt.wr_n = 1'b1;
        // A length of zero is reserved and never starts anything.
        if (pend_r && reg_upload && !act_r && len != 15'h0000) begin
          // A command written on this same edge stays pending for a later start.
          pend_nxt = reg_req.wr && reg_req.addr == `EBP_OFS_COMMAND;
          act_nxt = 1'b1;
          blk_nxt = len > `EBP_IMM_MAX;
          stop_nxt = 1'b0;
          idx_nxt = 2'h0;
          asm_nxt = 32'h00000000;
          gap_nxt = `EBP_ADDR_CYC;
          st_nxt = EBP_ADDR;
          pins_nxt.ale = 1'b1;
          pins_nxt.ad_oe = 1'b1;
          pins_nxt.ad_out = cmd_r[15:0];
        end
      end
      EBP_ADDR: begin
        gap_nxt = gap_r - 2'h1;
        if (gap_r == 2'h1 && can_go) begin
          st_nxt = EBP_STRB;
          tmr_nxt = 4'h0;
          pins_nxt.ad_oe = !dir_rd;
          pins_nxt.ad_out = wide2 ? shifted[15:0] : {8'h00, shifted[7:0]};
          // Separate strobes, or one data strobe with a direction level.
          if (cfg_r[`EBP_CFG_STROBE_STYLE]) begin
            pins_nxt.rd_n = !dir_rd;
            pins_nxt.wr_n = dir_rd;
          end else begin
            pins_nxt.rd_n = 1'b0;
            pins_nxt.wr_n = dir_rd;
          end
        end else if (gap_r == 2'h1) begin
          gap_nxt = 2'h1;
        end
      end
      EBP_STRB: begin
        // Saturates so that a long ready wait cannot wrap past the setting.
        tmr_nxt = (tmr_r == 4'hF) ? tmr_r : 4'(tmr_r + 4'h1);
        if (strobe_done) begin
          pins_nxt.rd_n = 1'b1;
          pins_nxt.wr_n = cfg_r[`EBP_CFG_STROBE_STYLE] ? 1'b1 : dir_rd;
          if (dir_rd) begin
            // Each Dword starts clean at byte zero, so the FIFO gets the whole word.
            asm_nxt = (idx_r == 2'h0) ? 32'h00000000 : asm_r;
            asm_nxt[{idx_r, 3'h0} +: 8] = ad_s2_r[7:0];
            if (wide2) begin
              asm_nxt[{idx_r + 2'h1, 3'h0} +: 8] = ad_s2_r[15:8];
            end
            if (!blk_r) begin
              ad_nxt = asm_nxt;
            end
          end
          cmd_nxt[`EBP_CMD_LEN_HI:`EBP_CMD_LEN_LO] = len - nbytes;
          if (cfg_r[`EBP_CFG_INCR]) begin
            cmd_nxt[15:0] = cmd_r[15:0] + 16'(nbytes);
          end
          idx_nxt = last ? 2'h0 : 2'(idx_r + nbytes[1:0]);
          gap_nxt = cfg_r[`EBP_CFG_FAST] ? `EBP_GAP_FAST : `EBP_GAP_SLOW;
          st_nxt = EBP_GAP;
          if (halt_req && !cfg_r[`EBP_CFG_RESUME]) begin
            stop_nxt = 1'b1;
          end
        end
      end
      EBP_GAP: begin
        pins_nxt.ad_oe = 1'b0;
        gap_nxt = gap_r - 2'h1;
        if (gap_r == 2'h1) begin
          if (len == 15'h0000 || stop_r) begin
            st_nxt = EBP_IDLE;
            act_nxt = 1'b0;
            blk_nxt = 1'b0;
          end else if (halt_req && cfg_r[`EBP_CFG_RESUME]) begin
            st_nxt = EBP_HOLD;
            gap_nxt = 2'h1;
          end else if (!cfg_r[`EBP_CFG_INCR] && can_go) begin
            // Without increment the idle gap alone separates two strobes.
            st_nxt = EBP_STRB;
            tmr_nxt = 4'h0;
            pins_nxt.ad_oe = !dir_rd;
            pins_nxt.ad_out = wide2 ? shifted[15:0] : {8'h00, shifted[7:0]};
            pins_nxt.rd_n = cfg_r[`EBP_CFG_STROBE_STYLE] ? !dir_rd : 1'b0;
            pins_nxt.wr_n = dir_rd;
          end else begin
            st_nxt = EBP_ADDR;
            gap_nxt = cfg_r[`EBP_CFG_INCR] ? `EBP_ADDR_CYC : 2'h1;
            pins_nxt.ale = cfg_r[`EBP_CFG_INCR];
            pins_nxt.ad_oe = cfg_r[`EBP_CFG_INCR];
            pins_nxt.ad_out = cmd_r[15:0];
          end
        end
      end
      EBP_HOLD: begin
        // Address lines float while waiting for the halt input to release.
        pins_nxt.ad_oe = 1'b0;
        if (halt_s2_r || !cfg_r[`EBP_CFG_HALT_EN]) begin
          st_nxt = EBP_ADDR;
          gap_nxt = `EBP_ADDR_CYC;
          pins_nxt.ale = 1'b1;
          pins_nxt.ad_oe = 1'b1;
          pins_nxt.ad_out = cmd_r[15:0];
        end
      end
      default: begin
        st_nxt = EBP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r <= `EBP_CFG_RESET;
      cmd_r <= `EBP_REG_RESET;
      page_r <= `EBP_REG_RESET;
      ad_r <= `EBP_REG_RESET;
      rdata_r <= `EBP_REG_RESET;
      asm_r <= `EBP_REG_RESET;
      rvalid_r <= 1'b0;
      pend_r <= 1'b0;
      blk_r <= 1'b0;
      stop_r <= 1'b0;
      act_r <= 1'b0;
      st_r <= EBP_IDLE;
      tmr_r <= 4'h0;
      idx_r <= 2'h0;
      gap_r <= 2'h0;
      pins_r <= {1'b0, 1'b1, 1'b1, 1'b0, 16'h0000};
      pbase_r <= 20'h00000;
    end else begin
      cfg_r <= cfg_nxt;
      cmd_r <= cmd_nxt;
      page_r <= page_nxt;
      ad_r <= ad_nxt;
      rdata_r <= rdata_nxt;
      asm_r <= asm_nxt;
      rvalid_r <= rvalid_nxt;
      pend_r <= pend_nxt;
      blk_r <= blk_nxt;
      stop_r <= stop_nxt;
      act_r <= act_nxt;
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      idx_r <= idx_nxt;
      gap_r <= gap_nxt;
      pins_r <= pins_nxt;
      pbase_r <= pbase_nxt;
    end
  end

  // Outputs from flip-flops.
  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign dma_addr = ad_r;
  assign dma_page_base = pbase_r;
  assign dma_page_en = page_r[`EBP_PAGE_EN];
  assign pins = pins_r;
  assign active = act_r;

  // Strobe width counted from its first cycle.
  logic [4:0] sw_cnt;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sw_cnt <= 5'h00;
    end else begin
      sw_cnt <= (st_r != EBP_STRB) ? 5'h00 : (sw_cnt == 5'h1F) ? sw_cnt : 5'(sw_cnt + 1'b1);
    end
  end

  sequence start_s;
    st_r == EBP_IDLE && pend_r && reg_upload && len != 15'h0000;
  endsequence
  strobe_width_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_r == EBP_STRB && !cfg_r[`EBP_CFG_TMR_EN_N] && rdy_s2_r)
      |-> strobe_done == (sw_cnt >= 5'(cfg_r[`EBP_CFG_TMR_HI:`EBP_CFG_TMR_LO])))
    else $error("strobe width differs from timer setting plus one");
  start_upload_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    start_s |=> act_r && pins_r.ale && pins_r.ad_out == $past(cmd_r[15:0]))
    else $error("transfer did not start after upload");
  zero_len_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_r == EBP_IDLE && len == 15'h0000) |=> !act_r)
    else $error("zero length started a transfer");
  cfg_reserved_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cfg_r & ~`EBP_CFG_MASK) == 32'h00000000 && (page_r & ~`EBP_PAGE_MASK) == 32'h00000000)
    else $error("reserved bits are set");
  page_gate_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !$past(page_r[`EBP_PAGE_EN]) |-> pbase_r == 20'h00000)
    else $error("page base visible while paging off");
  len_count_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_r == EBP_STRB && strobe_done) |=> len == $past(len) - $past(nbytes))
    else $error("remaining length not updated");
  halt_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_r == EBP_HOLD && !halt_s2_r && cfg_r[`EBP_CFG_HALT_EN]) |=> st_r == EBP_HOLD && act_r)
    else $error("halted block left wait state early");
  halt_stop_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_r == EBP_GAP && stop_r && gap_r == 2'h1) |=> !act_r)
    else $error("halt without resume did not end block");
  narrow_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_r == EBP_STRB && !cfg_r[`EBP_CFG_WIDE]) |-> nbytes == 15'h0001)
    else $error("wide cycle on narrow target");
  addr_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (act_r && !cfg_r[`EBP_CFG_INCR]) |=> cmd_r[15:0] == $past(cmd_r[15:0]))
    else $error("target address moved with increment off");
endmodule // ebp_top

// ==== test/ebp_target_model.sv ====
// Behavioural target peripheral on the expansion bus, with counters for the bench.
`timescale 1ns/100ps
module ebp_target_model (
  // Clock and bench controls.
  input wire logic clk_sys,
  input wire logic clr,
  input wire logic strobe_style,
  input wire logic [3:0] rdy_delay,
  // Device pins and the lines this target drives back.
  input wire ebp_pkg::ebp_pins_t pins,
  output logic [15:0] tgt_ad_in,
  output logic tgt_rdy,
  // What the target saw.
  output int n_ale,
  output int n_wr,
  output int n_rd,
  output int last_len,
  output int last_gap,
  output logic [15:0] last_addr,
  output logic [15:0] wr_log [8]
);
  import ebp_pkg::*;
  logic wr_act;
  logic rd_act;
  int len;
  int gap;
  logic was_wr;
  // Either handshake style decodes to one read and one write strobe.
  assign wr_act = strobe_style ? !pins.wr_n : (!pins.rd_n && !pins.wr_n);
  assign rd_act = strobe_style ? !pins.rd_n : (!pins.rd_n && pins.wr_n);
  // Start from a quiet, ready target.
  initial begin
    tgt_ad_in = 16'h0000;
    tgt_rdy = 1'b1;
    {n_ale, n_wr, n_rd, last_len, last_gap, len, gap} = '0;
    last_addr = 16'h0000;
    was_wr = 1'b0;
  end
  // Released data lines toggle, so a design that samples late sees garbage.
  always @(posedge clk_sys) begin
    tgt_ad_in <= rd_act ? ~last_addr : ~tgt_ad_in;
    tgt_rdy <= !((wr_act || rd_act) && len < int'(rdy_delay));
    if (pins.ale) begin
      last_addr <= pins.ad_out;
      n_ale <= n_ale + 1;
    end
    if (wr_act || rd_act) begin
      if (len == 0) last_gap <= gap;
      len <= len + 1;
      gap <= 0;
      was_wr <= wr_act;
      if (wr_act) wr_log[n_wr[2:0]] <= pins.ad_out;
    end else begin
      gap <= gap + 1;
      if (len != 0) begin
        last_len <= len;
        len <= 0;
        if (was_wr) n_wr <= n_wr + 1;
        else n_rd <= n_rd + 1;
      end
    end
    if (clr) begin
      n_ale <= 0;
      n_wr <= 0;
      n_rd <= 0;
    end
  end
endmodule // ebp_target_model

// ==== test/testbench.sv ====
// Self-checking bench of the expansion bus port against a target model.
`timescale 1ns/100ps
module testbench;
  import ebp_pkg::*;
  localparam logic [31:0] C_STY = 32'h00020000;
  localparam logic [31:0] C_WIDE = 32'h00080000;
  localparam logic [31:0] C_FAST = 32'h10000000;
  localparam logic [31:0] C_INC = 32'h00040000;
  localparam logic [31:0] C_T3 = 32'h00C00000;
  localparam logic [15:0] W0 [3] = '{16'h3344, 16'h4433, 16'h2211};
  localparam logic [15:0] W1 [3] = '{16'h1122, 16'h2211, 16'h4433};
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  ebp_reg_req_t reg_req;
  logic reg_upload;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  logic dma_in_valid;
  logic [31:0] dma_in_data;
  logic dma_in_ready;
  logic dma_out_valid;
  logic [31:0] dma_out_data;
  logic dma_out_ready;
  logic [31:0] dma_addr;
  logic [19:0] dma_page_base;
  logic dma_page_en;
  ebp_pins_t pins;
  logic [15:0] tgt_ad_in;
  logic tgt_rdy;
  logic ext_halt_input;
  logic active;
  logic clr;
  logic style;
  logic [3:0] rdy_delay;
  int n_ale;
  int n_wr;
  int n_rd;
  int last_len;
  int last_gap;
  logic [15:0] last_addr;
  logic [15:0] wr_log [8];
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  int n_rx = 0;
  logic [31:0] rx;
  logic [31:0] feed [4];
  int fi = 0;
  int fn = 0;
  logic [31:0] v;
  int i;

  ebp_top ebp_top_i (.clk_sys, .arst_n, .reg_req, .reg_upload, .reg_rdata, .reg_rvalid,
    .dma_in_valid, .dma_in_data, .dma_in_ready, .dma_out_valid, .dma_out_data, .dma_out_ready,
    .dma_addr, .dma_page_base, .dma_page_en, .pins, .tgt_ad_in, .tgt_rdy, .ext_halt_input,
    .active);
  ebp_target_model ebp_target_model_i (.clk_sys, .clr, .strobe_style(style), .rdy_delay,
    .pins, .tgt_ad_in, .tgt_rdy, .n_ale, .n_wr, .n_rd, .last_len, .last_gap, .last_addr,
    .wr_log);

  // Clock at 50 MHz.
  always #10 clk_sys = ~clk_sys;

  // DMA source hands out the loaded Dwords one per accepted handshake.
  always @(posedge clk_sys) begin
    if (dma_in_valid && dma_in_ready) fi = fi + 1;
    dma_in_valid <= fi < fn;
    dma_in_data <= feed[fi[1:0]];
  end

  // DMA sink records the Dwords drained from block reads.
  always @(posedge clk_sys) begin
    if (dma_out_valid && dma_out_ready) begin
      rx <= dma_out_data;
      n_rx <= n_rx + 1;
    end
  end

  // A hung transfer must not stall the run forever.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    reg_req <= '0;
  endtask

  // Read data arrives with the one-cycle valid pulse after the request edge.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk_sys);
    reg_req <= '0;
    #1;
    chk("rvalid", {31'h0, reg_rvalid}, 32'h1);
    d = reg_rdata;
  endtask

  function automatic logic [31:0] cmd(input logic [14:0] len, input logic dir,
                                      input logic [15:0] a);
    return {len, dir, a};
  endfunction

  task automatic start(input logic [31:0] cfg, input logic [31:0] ad, input logic [31:0] c);
    wr(8'h7C, cfg);
    wr(8'h88, ad);
    wr(8'h80, c);
    @(posedge clk_sys);
    clr <= 1'b1;
    reg_upload <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    reg_upload <= 1'b0;
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    #1;
    chk("started", {31'h0, active}, 32'h1);
    while (active !== 1'b0 && k < 3000) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    chk("finished", {31'h0, active}, 32'h0);
  endtask

  task automatic run(input logic [31:0] cfg, input logic [31:0] ad, input logic [31:0] c);
    start(cfg, ad, c);
    wait_idle();
  endtask

  // Main sequence: registers first, then immediate, block and halted transfers.
  initial begin
    reg_req = '0;
    reg_upload = 1'b0;
    dma_in_valid = 1'b0;
    dma_in_data = 32'h0;
    dma_out_ready = 1'b1;
    ext_halt_input = 1'b1;
    clr = 1'b0;
    style = 1'b1;
    rdy_delay = 4'h0;
    feed = '{32'h11223344, 32'h55667788, 32'h99AABBCC, 32'hDDEEFF00};
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(8'h7C, v);
    chk("cfg_reset", v, 32'h00010000);
    for (i = 0; i < 4; i++) begin
      rd(8'(8'h80 + 4 * i), v);
      chk("reg_reset", v, 32'h0);
    end
    wr(8'h7C, 32'hFFFFFFFF);
    rd(8'h7C, v);
    chk("cfg_mask", v, 32'hD3FF0000);
    wr(8'h84, 32'hFFFFFFFF);
    rd(8'h84, v);
    chk("page_mask", v, 32'hFFFFF800);
    chk("page_en", {31'h0, dma_page_en}, 32'h1);
    chk("page_base", {12'h0, dma_page_base}, 32'h000FFFFF);
    wr(8'h84, 32'hABCDE000);
    rd(8'h84, v);
    chk("page_off", {12'h0, dma_page_base}, 32'h0);
    chk("page_dis", {31'h0, dma_page_en}, 32'h0);
    wr(8'h88, 32'h12345678);
    rd(8'h88, v);
    chk("addr_data", dma_addr, 32'h12345678);
    // Immediate 16-bit writes with the strobe timer at zero and at three.
    for (i = 0; i < 2; i++) begin
      run(C_STY | C_WIDE | C_FAST | (i == 0 ? 32'h0 : C_T3), 32'h0000BEEF, cmd(2, 0, 16'h0040));
      chk("wr_count", n_wr, 1);
      chk("wr_data", {16'h0, wr_log[0]}, 32'h0000BEEF);
      chk("tgt_addr", {16'h0, last_addr}, 32'h00000040);
      chk("strobe_len", last_len, i == 0 ? 1 : 4);
    end
    run(C_STY | C_FAST, 32'h0000BEEF, cmd(2, 0, 16'h0040));
    chk("byte_count", n_wr, 2);
    chk("byte_hi", {24'h0, wr_log[1][7:0]}, 32'h000000BE);
    style = 1'b0;
    run(C_WIDE | C_FAST, 32'h0000BEEF, cmd(2, 0, 16'h0040));
    chk("alt_style", {16'h0, wr_log[0]}, 32'h0000BEEF);
    style = 1'b1;
    run(C_STY | C_WIDE | C_FAST | C_T3, 32'h0, cmd(2, 1, 16'h1234));
    chk("rd_count", n_rd, 1);
    rd(8'h88, v);
    chk("rd_data", {16'h0, v[15:0]}, 32'h0000EDCB);
    // A slow target holds ready low; the strobe waits for it past the timer.
    rdy_delay = 4'h5;
    run(C_STY | C_WIDE | C_T3, 32'h0000BEEF, cmd(2, 0, 16'h0040));
    chk("rdy_stretch", last_len, 9);
    rdy_delay = 4'h0;
    // With the timer disabled its setting no longer widens the strobe.
    run(C_STY | C_WIDE | C_T3 | 32'h00010000, 32'h0000BEEF, cmd(2, 0, 16'h0040));
    chk("timer_off", last_len, 1);
    // Block writes over the swap codes, with and without increment and fast mode.
    for (i = 0; i < 3; i++) begin
      fi = 0;
      fn = 2;
      run(C_STY | C_WIDE | (32'(i) << 20) | (i == 2 ? C_INC : 32'h0) | (i != 1 ? C_FAST : 32'h0),
          32'h00001000, cmd(8, 0, 16'h0100));
      chk("blk_count", n_wr, 4);
      chk("swap_w0", {16'h0, wr_log[0]}, {16'h0, W0[i]});
      chk("swap_w1", {16'h0, wr_log[1]}, {16'h0, W1[i]});
      chk("ale_count", n_ale, i == 2 ? 4 : 1);
      chk("last_addr", {16'h0, last_addr}, i == 2 ? 32'h0106 : 32'h0100);
      if (i != 2) chk("idle_gap", last_gap, i == 0 ? 1 : 2);
      rd(8'h80, v);
      chk("left_len", {17'h0, v[31:17]}, 32'h0);
    end
    // Block read of two Dwords with a 2-byte swap, drained on the DMA side.
    run(C_STY | C_WIDE | C_FAST | C_T3 | 32'h00100000, 32'h00002000, cmd(8, 1, 16'h0312));
    chk("rd_blk_n", n_rx, 2);
    chk("rd_blk_dw", rx, 32'hEDFCEDFC);
    chk("rd_blk_cnt", n_rd, 4);
    chk("rd_blk_addr", dma_addr, 32'h00002008);
    // Halt input ignored while its enable is clear.
    fi = 0;
    fn = 4;
    @(posedge clk_sys);
    ext_halt_input <= 1'b0;
    run(C_STY | C_WIDE | C_FAST, 32'h00001000, cmd(16, 0, 16'h0200));
    chk("no_halt", n_wr, 8);
    // Halt with resume parks the bus, then finishes the block.
    @(posedge clk_sys);
    ext_halt_input <= 1'b1;
    fi = 0;
    fn = 4;
    start(32'hC0000000 | C_STY | C_WIDE | C_FAST | C_T3, 32'h00001000, cmd(16, 0, 16'h0200));
    repeat (6) @(posedge clk_sys);
    ext_halt_input <= 1'b0;
    repeat (30) @(posedge clk_sys);
    #1;
    chk("held_active", {31'h0, active}, 32'h1);
    chk("held_float", {31'h0, pins.ad_oe}, 32'h0);
    @(posedge clk_sys);
    ext_halt_input <= 1'b1;
    wait_idle();
    chk("resumed", n_wr, 8);
    // Halt without resume ends the block early with length left over.
    fi = 0;
    fn = 4;
    start(32'h80000000 | C_STY | C_WIDE | C_FAST | C_T3, 32'h00001000, cmd(16, 0, 16'h0200));
    repeat (6) @(posedge clk_sys);
    ext_halt_input <= 1'b0;
    wait_idle();
    chk("aborted", {31'h0, n_wr < 8}, 32'h1);
    rd(8'h80, v);
    chk("len_left", {31'h0, v[31:17] != 15'h0}, 32'h1);
    end_of_test();
  end
endmodule // testbench
